// ===== src/mss_pkg.sv
package mss_pkg;
   // register byte offsets
   localparam logic [5:0] OFS_CTRL = 6'h00;
   localparam logic [5:0] OFS_START = 6'h04;
   localparam logic [5:0] OFS_WAIT = 6'h08;
   localparam logic [5:0] OFS_HLIM = 6'h0C;
   localparam logic [5:0] OFS_EVEN = 6'h10;
   localparam logic [5:0] OFS_STAT = 6'h14;
   localparam logic [5:0] OFS_IST = 6'h18;
   localparam logic [5:0] OFS_IMSK = 6'h1C;
   localparam logic [5:0] OFS_TIME = 6'h20;
   localparam logic [5:0] OFS_LSEL = 6'h24;
   localparam logic [5:0] OFS_LOG0 = 6'h28;
   localparam logic [5:0] OFS_LOG4 = 6'h38;
   // control bit positions
   localparam int CTL_HEAT = 0;
   localparam int CTL_SWEN = 1;
   localparam int CTL_SWNC = 2;
   localparam int CTL_STALL = 3;
   localparam int EVEN_OFF = 8;
   // event bit positions
   localparam int EV_MAXST = 0;
   localparam int EV_SETST = 1;
   localparam int EV_NOSW = 2;
   localparam int EV_START = 3;
   localparam int EV_SETTRIP = 4;
   localparam int EV_CAPTRIP = 5;
   localparam int EV_BLK = 6;
   localparam int NEV = 7;
   localparam int LOG_DEPTH = 12;
   // settings in 5 ms steps, 40 ms default
   localparam int STEP_MS = 5;
   localparam logic [18:0] START_DEF = 19'h00008;
   localparam logic [18:0] WAIT_DEF = 19'h00008;
   localparam logic [31:0] HLIM_DEF = 32'h0001_0000;
   localparam logic [6:0] EVEN_DEF = 7'h7F;
   localparam logic [7:0] PCT_FULL = 8'h64;
   // timing
   localparam int CLK_HZ = 100_000_000;
   localparam int TICK_MS = 1;
   localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS;
   // settings
   typedef struct packed {
      logic heat; logic swen; logic swnc; logic stall;
      logic [18:0] st; logic [18:0] wt; logic [31:0] hlim;
      logic [6:0] on_en; logic [6:0] off_en; logic [6:0] imsk;
   } mss_cfg_t;
   // measurement inputs
   typedef struct packed {
      logic [15:0] i1; logic [15:0] i2; logic [15:0] i3;
      logic [7:0] cap; logic [1:0] grp;
   } mss_meas_t;
   // operation record
   typedef struct packed {
      logic [31:0] ts; logic [7:0] ev; logic [23:0] dur;
      logic [7:0] pct; mss_meas_t m;
   } mss_rec_t;
   // whole block state
   typedef struct packed {
      logic [31:0] div; logic [31:0] now; logic s1; logic s2;
      mss_cfg_t cfg; logic [23:0] dur; logic [31:0] acc;
      logic [23:0] frac; logic [7:0] pct; logic seen; logic nosw;
      logic [6:0] lv; logic trip; logic [6:0] ist; logic irq;
      logic [3:0] sel; logic [31:0] rdata; mss_rec_t [11:0] log;
   } mss_st_t;
endpackage : mss_pkg

// ===== src/mss_top.sv
`timescale 1ns/1ps
`default_nettype none
// Function
// R1 - starting time set in 5 ms steps
// R2 - definite mode times condition against setting
// R3 - heating mode integrates current squared instead
// R4 - missing tacho contact within wait halts start
// R5 - tacho contact polarity open or closed
// R6 - tacho supervision enable, default off
// R7 - starts only or starts and stall
// R8 - start output while condition pends trip
// R9 - trip when pick-up and time met
// R10 - blocked when started but inhibited
// R11 - per event store on, off or both
// R12 - every stored event carries time stamp
// R13 - on and off events per kind
// R14 - keep twelve newest records, drop oldest
// R15 - record holds time, event, duration, currents
// R16 - blocking suppresses trip, start still tracked
module mss_top #(
   parameter int TICK_CYC = mss_pkg::TICK_CYC
) (
   // clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // register port
   input wire logic [5:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [31:0] rdata,
   // motor side
   input wire logic stall_cond,
   input wire logic motor_starting,
   input wire logic blk,
   input wire logic tacho_contact,
   input wire mss_pkg::mss_meas_t meas,
   // outputs
   output logic start_o,
   output logic trip_o,
   output logic blocked_o,
   output logic irq_o
);
   // refuse a divider that cannot count
   if (TICK_CYC < 2) begin : g_chk
      $error("TICK_CYC must be at least 2");
   end

   mss_pkg::mss_st_t q; // registered state
   mss_pkg::mss_st_t n; // next state
   logic cond; // supervised condition
   logic tick; // one millisecond enable
   logic sw_on; // tacho active after polarity
   logic [23:0] set_ms; // starting time in ms
   logic [23:0] wait_ms; // tacho wait in ms
   logic [31:0] sq; // square of largest current
   logic [15:0] imax; // largest phase current
   logic [6:0] lv; // event levels
   logic [6:0] rise; // on edges
   logic [6:0] fall; // off edges
   logic [6:0] ist_clr; // write-one-to-clear bits
   logic store; // a record is taken
   logic [7:0] ev_code; // recorded event code

   // one word of a record
   function automatic logic [31:0] rec_word(input mss_pkg::mss_rec_t r,
                                            input logic [5:0] a);
      logic [31:0] w;
      w = 32'h0000_0000;
      case (a)
         mss_pkg::OFS_LOG0: w = r.ts;
         6'h2C: w = {r.ev, r.pct, r.m.cap, 6'h00, r.m.grp};
         6'h30: w = {8'h00, r.dur};
         6'h34: w = {r.m.i1, r.m.i2};
         mss_pkg::OFS_LOG4: w = {16'h0000, r.m.i3};
         default: w = 32'h0000_0000;
      endcase
      return w;
   endfunction : rec_word

   // next state
   always_comb begin
      n = q;
      ist_clr = 7'h00;
      store = 1'b0;
      ev_code = 8'h00;
      // millisecond divider and time stamp clock
      tick = (q.div == 32'(TICK_CYC - 1));
      n.div = tick ? 32'h0000_0000 : q.div + 32'h0000_0001;
      if (tick) begin
         n.now = q.now + 32'h0000_0001; // R12
      end
      // tacho contact synchroniser
      n.s1 = tacho_contact;
      n.s2 = q.s1;
      sw_on = q.s2 ^ q.cfg.swnc; // R5
      // start only or start and stall
      cond = stall_cond & (q.cfg.stall | motor_starting); // R7
      set_ms = 24'(q.cfg.st) * 24'(mss_pkg::STEP_MS); // R1
      wait_ms = 24'(q.cfg.wt) * 24'(mss_pkg::STEP_MS);
      imax = (meas.i1 > meas.i2) ? meas.i1 : meas.i2;
      imax = (meas.i3 > imax) ? meas.i3 : imax;
      sq = imax * imax;
      // duration, heating and set-time share
      if (!cond) begin
         n.dur = 24'h00_0000;
         n.acc = 32'h0000_0000;
         n.frac = 24'h00_0000;
         n.pct = 8'h00;
         n.seen = 1'b0;
      end else if (tick) begin
         if (q.dur != 24'hFF_FFFF) begin
            n.dur = q.dur + 24'h00_0001; // R2
         end
         if (q.acc <= 32'hFFFF_FFFF - {8'h00, sq[31:8]}) begin
            n.acc = q.acc + {8'h00, sq[31:8]}; // R3
         end else begin
            n.acc = 32'hFFFF_FFFF;
         end
         n.frac = q.frac + 24'(mss_pkg::PCT_FULL);
         if (sw_on) begin
            n.seen = 1'b1;
         end
      end else begin
         if (set_ms == 24'h00_0000) begin
            n.pct = 8'hFF;
         end else if (q.frac >= set_ms && q.pct != 8'hFF) begin
            n.frac = q.frac - set_ms; // one percent per pass
            n.pct = q.pct + 8'h01;
         end
         if (sw_on) begin
            n.seen = 1'b1;
         end
      end
      // tacho not received within wait
      n.nosw = cond & (q.nosw | (q.cfg.swen & ~q.seen & ~sw_on
                                 & (q.dur >= wait_ms))); // R4 R6
      // event levels
      lv[mss_pkg::EV_SETST] = cond & ~q.cfg.heat & (q.dur >= set_ms); // R2
      lv[mss_pkg::EV_MAXST] = cond & q.cfg.heat & (q.acc >= q.cfg.hlim); // R3
      lv[mss_pkg::EV_NOSW] = q.nosw;
      lv[mss_pkg::EV_START] = cond; // R8
      lv[mss_pkg::EV_SETTRIP] = lv[mss_pkg::EV_SETST] & ~blk; // R16
      lv[mss_pkg::EV_CAPTRIP] = lv[mss_pkg::EV_MAXST] & ~blk; // R16
      lv[mss_pkg::EV_BLK] = cond & blk; // R10
      n.lv = lv;
      n.trip = ~blk & (lv[mss_pkg::EV_SETST] | lv[mss_pkg::EV_MAXST]
                       | q.nosw); // R9 R4 R16
      rise = lv & ~q.lv; // R13
      fall = ~lv & q.lv; // R13
      // pick one stored edge, lowest kind first
      for (int i = mss_pkg::NEV - 1; i >= 0; i--) begin
         if (rise[i] & q.cfg.on_en[i]) begin
            store = 1'b1; // R11
            ev_code = {4'h1, 4'(i)};
         end else if (fall[i] & q.cfg.off_en[i]) begin
            store = 1'b1; // R11
            ev_code = {4'h0, 4'(i)};
         end
      end
      // newest record at index 0, oldest falls off
      if (store) begin
         for (int i = mss_pkg::LOG_DEPTH - 1; i > 0; i--) begin
            n.log[i] = q.log[i-1]; // R14
         end
         n.log[0].ts = q.now; // R12
         n.log[0].ev = ev_code; // R15
         n.log[0].dur = q.dur;
         n.log[0].pct = q.pct;
         n.log[0].m = meas;
      end
      // register writes
      if (wr) begin
         case (addr)
            mss_pkg::OFS_CTRL: begin
               n.cfg.heat = wdata[mss_pkg::CTL_HEAT];
               n.cfg.swen = wdata[mss_pkg::CTL_SWEN];
               n.cfg.swnc = wdata[mss_pkg::CTL_SWNC];
               n.cfg.stall = wdata[mss_pkg::CTL_STALL];
            end
            mss_pkg::OFS_START: n.cfg.st = wdata[18:0]; // R1
            mss_pkg::OFS_WAIT: n.cfg.wt = wdata[18:0];
            mss_pkg::OFS_HLIM: n.cfg.hlim = wdata;
            mss_pkg::OFS_EVEN: begin
               n.cfg.on_en = wdata[6:0];
               n.cfg.off_en = wdata[mss_pkg::EVEN_OFF +: 7];
            end
            mss_pkg::OFS_IST: ist_clr = wdata[6:0];
            mss_pkg::OFS_IMSK: n.cfg.imsk = wdata[6:0];
            mss_pkg::OFS_TIME: n.now = wdata;
            mss_pkg::OFS_LSEL: n.sel = wdata[3:0];
            default: ; // unmapped writes ignored
         endcase
      end
      // sticky status, a new edge beats the clear
      n.ist = (q.ist & ~ist_clr) | rise;
      n.irq = |(n.ist & n.cfg.imsk);
      // register reads, data in the next cycle
      n.rdata = 32'h0000_0000;
      if (rd) begin
         case (addr)
            mss_pkg::OFS_CTRL: n.rdata = {28'h000_0000, q.cfg.stall, q.cfg.swnc,
                                          q.cfg.swen, q.cfg.heat};
            mss_pkg::OFS_START: n.rdata = {13'h0000, q.cfg.st};
            mss_pkg::OFS_WAIT: n.rdata = {13'h0000, q.cfg.wt};
            mss_pkg::OFS_HLIM: n.rdata = q.cfg.hlim;
            mss_pkg::OFS_EVEN: n.rdata = {17'h0_0000, q.cfg.off_en, 1'b0,
                                          q.cfg.on_en};
            mss_pkg::OFS_STAT: n.rdata = {q.pct, q.dur[15:0], q.trip, q.lv};
            mss_pkg::OFS_IST: n.rdata = {25'h000_0000, q.ist};
            mss_pkg::OFS_IMSK: n.rdata = {25'h000_0000, q.cfg.imsk};
            mss_pkg::OFS_TIME: n.rdata = q.now;
            mss_pkg::OFS_LSEL: n.rdata = {28'h000_0000, q.sel};
            default: begin
               if (addr >= mss_pkg::OFS_LOG0 && addr <= mss_pkg::OFS_LOG4
                   && q.sel < 4'(mss_pkg::LOG_DEPTH)) begin
                  n.rdata = rec_word(q.log[q.sel], addr);
               end
            end
         endcase
      end
   end

   // state register
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         // everything clear, then the documented setting defaults
         q <= '0;
         q.cfg.st <= mss_pkg::START_DEF;
         q.cfg.wt <= mss_pkg::WAIT_DEF;
         q.cfg.hlim <= mss_pkg::HLIM_DEF;
         q.cfg.on_en <= mss_pkg::EVEN_DEF;
         q.cfg.off_en <= mss_pkg::EVEN_DEF;
      end else begin
         q <= n;
      end
   end

   // outputs straight from flops
   assign rdata = q.rdata;
   assign start_o = q.lv[mss_pkg::EV_START];
   assign trip_o = q.trip;
   assign blocked_o = q.lv[mss_pkg::EV_BLK];
   assign irq_o = q.irq;

   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);

   a_blk_no_trip: assert property (blk |=> !trip_o) // R16
      else $error("trip while blocked");
   a_start_follow: assert property (stall_cond && motor_starting |=> start_o) // R8
      else $error("start not raised");
   a_blocked_start: assert property (blocked_o |-> start_o) // R10
      else $error("blocked without start");
   // trip level and its cause levels are registered on the same edge
   a_trip_cause: assert property ($rose(trip_o) |->
      q.lv[mss_pkg::EV_SETST] | q.lv[mss_pkg::EV_MAXST] | $past(q.nosw)) // R9
      else $error("trip without cause");
   // the level was judged against the settings of the previous cycle
   a_def_time: assert property (q.lv[mss_pkg::EV_SETST] |->
      $past(!q.cfg.heat) && $past(q.dur >= set_ms)) // R2
      else $error("set time early");
   a_heat_excl: assert property ($past(q.cfg.heat) |-> !q.lv[mss_pkg::EV_SETST]) // R3
      else $error("definite event in heating mode");
   a_tacho_en: assert property (q.nosw |-> q.cfg.swen) // R6
      else $error("tacho fault while disabled");
   a_log_stamp: assert property (store |=> q.log[0].ts == $past(q.now)
      && q.log[1] == $past(q.log[0])) // R14
      else $error("record not shifted");
   // the stored event code is the one picked in the cycle before
   a_rec_code: assert property (store |=> q.log[0].ev == $past(ev_code)) // R11
      else $error("record event code wrong");
   // duration restarts whenever the condition is gone
   a_dur_clear: assert property (!cond |=> q.dur == 24'h00_0000) // R2
      else $error("duration not cleared");
   // start output follows the condition down
   a_start_drop: assert property (!cond |=> !start_o) // R8
      else $error("start held without condition");
   // tacho fault stays latched while the condition holds
   a_nosw_hold: assert property (q.nosw && cond |=> q.nosw) // R4
      else $error("tacho fault dropped early");
   // rising edges always land in the sticky status, set beats clear
   a_ist_rise: assert property ((q.ist & $past(rise)) == $past(rise)) // R13
      else $error("event edge not latched");
   // status bits only leave by a written one
   a_ist_sticky: assert property (
      (($past(q.ist) & ~$past(ist_clr)) & ~q.ist) == 7'h00) // R13
      else $error("status bit lost");
   // interrupt level mirrors unmasked status
   a_irq_level: assert property (irq_o == |(q.ist & q.cfg.imsk)) // R13
      else $error("interrupt level wrong");
   // time stamp counter advances once per tick unless software loads it
   a_now_count: assert property ($past(tick) && !$past(wr && addr == mss_pkg::OFS_TIME)
      |-> q.now == $past(q.now) + 32'h0000_0001) // R12
      else $error("time stamp not counting");
   // records past the kept depth read as zero
   a_log_depth: assert property (rd && q.sel >= 4'(mss_pkg::LOG_DEPTH)
      && addr >= mss_pkg::OFS_LOG0 && addr <= mss_pkg::OFS_LOG4 |=> rdata == 32'h0000_0000) // R14
      else $error("record beyond depth");
   // read data stand only in the cycle after a read strobe
   a_rd_quiet: assert property (!rd |=> rdata == 32'h0000_0000)
      else $error("read data without strobe");

   // main scenarios
   c_trip: cover property (start_o ##[1:1000] trip_o);
   c_blocked: cover property ($rose(blocked_o));
   c_nosw: cover property ($rose(q.nosw));
   c_captrip: cover property ($rose(q.lv[mss_pkg::EV_CAPTRIP]));
   c_store: cover property (store && rise[mss_pkg::EV_START]);
endmodule : mss_top
`default_nettype wire

// ===== tb/mss_motor_model.sv
`timescale 1ns/1ps
`default_nettype none
// far side: speed switch on the shaft and the phase current measurement
module mss_motor_model (
   // shaft side
   input wire logic spin,
   input wire logic nc,
   // current level on phase one
   input wire logic [15:0] amps,
   // towards the device
   output logic tacho_contact,
   output mss_pkg::mss_meas_t meas
);
   // contact makes at speed; a closed-at-rest switch opens instead
   assign tacho_contact = spin ^ nc;
   // phases unbalanced, phase two at half and phase three at a quarter of phase one, capacity and group held fixed
   assign meas = '{i1: amps, i2: amps >> 1, i3: amps >> 2, cap: 8'h20, grp: 2'h1};
endmodule : mss_motor_model
`default_nettype wire

// ===== tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin n_errors++; \
   $display("CHECK FAILED %s exp %0h got %0h", n, e, s); end end
module tb;
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic [5:0] addr = 6'h00;
   logic [31:0] wdata = 32'h0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [31:0] rdata;
   logic stall_cond = 1'b0;
   logic motor_starting = 1'b0;
   logic blk = 1'b0;
   logic spin = 1'b0;
   logic nc = 1'b0;
   logic [15:0] amps = 16'h0000;
   logic tacho_contact;
   mss_pkg::mss_meas_t meas;
   logic start_o, trip_o, blocked_o, irq_o;
   int n_errors = 0;
   int cmp_count = 0;
   int cyc = 0;
   int n;
   logic [31:0] d;
   // 1 ms tick shortened to 10 clocks
   mss_top #(.TICK_CYC(10)) dut (.clk(clk), .arst_n(arst_n), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd), .rdata(rdata), .stall_cond(stall_cond),
      .motor_starting(motor_starting), .blk(blk), .tacho_contact(tacho_contact),
      .meas(meas), .start_o(start_o), .trip_o(trip_o), .blocked_o(blocked_o), .irq_o(irq_o));
   mss_motor_model motor (.spin(spin), .nc(nc), .amps(amps), .tacho_contact(tacho_contact),
      .meas(meas));
   // 100 MHz clock
   always #5 clk = ~clk;
   // hang guard
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         n_errors++;
         test_done();
      end
   end
   // verdict and end of run
   task automatic test_done();
      $display("checks %0d errors %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : test_done
   // one-cycle register write
   task automatic wr_reg(input logic [5:0] a, input logic [31:0] v);
      @(posedge clk);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wr_reg
   // read strobe, data taken in the following cycle
   task automatic rd_reg(input logic [5:0] a, output logic [31:0] v);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 v = rdata;
   endtask : rd_reg
   // count clocks until trip, bounded
   task automatic wait_trip(input int lim, output int k);
      k = 0;
      while (trip_o !== 1'b1 && k < lim) begin
         @(posedge clk);
         #1 k++;
      end
   endtask : wait_trip
   // one start attempt: clear status, set mode, run, read status, stop
   task automatic run(input logic [31:0] ctl, input int lim, output int k);
      wr_reg(mss_pkg::OFS_IST, 32'h7F);
      wr_reg(mss_pkg::OFS_CTRL, ctl);
      @(posedge clk);
      stall_cond <= 1'b1;
      motor_starting <= 1'b1;
      @(posedge clk);
      #1 `CHK("start_o", 1'b1, start_o)
      wait_trip(lim, k);
      rd_reg(mss_pkg::OFS_IST, d);
      @(posedge clk);
      stall_cond <= 1'b0;
      repeat (4) @(posedge clk);
   endtask : run
   initial begin
      repeat (8) @(posedge clk);
      arst_n <= 1'b1;
      // settings after reset
      rd_reg(mss_pkg::OFS_CTRL, d); `CHK("ctrl", 32'h0, d)
      rd_reg(mss_pkg::OFS_START, d); `CHK("start", 32'h8, d)
      rd_reg(mss_pkg::OFS_WAIT, d); `CHK("wait", 32'h8, d)
      rd_reg(mss_pkg::OFS_EVEN, d); `CHK("even", 32'h7F7F, d)
      rd_reg(6'h3C, d); `CHK("unmapped", 32'h0, d)
      // definite time, 10 ms, trip interrupt unmasked
      wr_reg(mss_pkg::OFS_TIME, 32'h1000);
      wr_reg(mss_pkg::OFS_START, 32'h2);
      wr_reg(mss_pkg::OFS_IMSK, 32'h10);
      run(32'h0, 300, n);
      `CHK("def time", 1'b1, n > 85 && n < 125)
      `CHK("def ist", 32'h1A, d & 32'h1A)
      `CHK("irq set", 1'b1, irq_o)
      `CHK("trip off", 1'b0, trip_o)
      wr_reg(mss_pkg::OFS_IST, 32'h7F);
      repeat (2) @(posedge clk);
      #1 `CHK("irq clr", 1'b0, irq_o)
      // newest record and depth limit
      wr_reg(mss_pkg::OFS_LSEL, 32'h0);
      rd_reg(mss_pkg::OFS_LOG0, d); `CHK("rec ts", 1'b1, d >= 32'h1000)
      rd_reg(6'h2C, d); `CHK("rec grp", 2'h1, d[1:0])
      wr_reg(mss_pkg::OFS_LSEL, 32'hC);
      rd_reg(mss_pkg::OFS_LOG0, d); `CHK("rec 12", 32'h0, d)
      // blocked start never trips
      @(posedge clk);
      blk <= 1'b1;
      stall_cond <= 1'b1;
      motor_starting <= 1'b1;
      repeat (150) @(posedge clk);
      #1 `CHK("blocked", 1'b1, blocked_o)
      `CHK("blk trip", 1'b0, trip_o)
      `CHK("blk start", 1'b1, start_o)
      rd_reg(mss_pkg::OFS_STAT, d); `CHK("stat lv", 8'h4A, d[7:0])
      // stall only supervised in starts-and-stall mode
      @(posedge clk);
      motor_starting <= 1'b0;
      blk <= 1'b0;
      repeat (5) @(posedge clk);
      #1 `CHK("no stall", 1'b0, start_o)
      wr_reg(mss_pkg::OFS_CTRL, 32'h8);
      repeat (3) @(posedge clk);
      #1 `CHK("stall", 1'b1, start_o)
      @(posedge clk);
      stall_cond <= 1'b0;
      // heating mode, masked capacity trip
      wr_reg(mss_pkg::OFS_START, 32'h7FFFF);
      wr_reg(mss_pkg::OFS_HLIM, 32'h10);
      amps <= 16'h0100;
      run(32'h1, 60, n);
      `CHK("heat time", 1'b1, n < 40)
      `CHK("heat ist", 32'h20, d & 32'h20)
      `CHK("irq mask", 1'b0, irq_o)
      // tacho missing within 5 ms
      @(posedge clk);
      amps <= 16'h0000;
      wr_reg(mss_pkg::OFS_WAIT, 32'h1);
      run(32'h2, 150, n);
      `CHK("tacho time", 1'b1, n > 35 && n < 80)
      `CHK("tacho ist", 32'h4, d & 32'h4)
      // normally closed contact opened at speed
      @(posedge clk);
      nc <= 1'b1;
      spin <= 1'b1;
      run(32'h6, 150, n);
      `CHK("nc ok", 150, n)
      test_done();
   end
endmodule : tb
`default_nettype wire
